//--- bench/linear_sensor_scan_timing_tb.sv
// testbench joining sensor and controller ends
`timescale 1ns/1ps
`default_nettype none
module linear_sensor_scan_timing_tb import scan_pkg::*;;
	typedef struct packed {
		logic [TIME_W-1:0] expo;
		logic [TIME_W-1:0] cyc;
		logic [CNT_W-1:0] want;
		logic [TIME_W-1:0] h_exp;
		logic [CNT_W-1:0] n_exp;
	} row_t;
	logic sys_clk, rstn, pix_wr_en, readout_busy, run, pix_valid, pix_ready;
	logic frame_done, overrun, scan_busy;
	logic [8:0] pix_wr_addr;
	logic [VIDEO_W-1:0] pix_wr_data, pix_data;
	logic [TIME_W-1:0] exposure_cycles, cycle_req, exposure_req;
	logic [CNT_W-1:0] pixels_wanted;
	int n_fail, comparisons, got, modn, cycles;
	int rise_q[$];
	logic ss_q;
	row_t rows[6] = '{
		'{23'h00000a, 23'h000258, 10'h004, 23'h00000a, 10'h004},
		'{23'h000002, 23'h000000, 10'h008, 23'h000006, 10'h008},
		'{23'h000208, 23'h000000, 10'h200, 23'h000208, 10'h200},
		'{23'h000040, 23'h000000, 10'h3ff, 23'h000040, 10'h200},
		'{23'h000006, 23'h000000, 10'h000, 23'h000006, 10'h000},
		'{23'h000020, 23'h000000, 10'h020, 23'h000020, 10'h020}};
	scan_link_if u_scan_link_if();
	scan_sensor u_scan_sensor(.sys_clk, .rstn, .lnk(u_scan_link_if), .pix_wr_en, .pix_wr_addr,
		.pix_wr_data, .exposure_cycles, .readout_busy);
	scan_ctrl #(.MAX_CYCLES(2000)) u_scan_ctrl(.sys_clk, .rstn, .lnk(u_scan_link_if), .run,
		.cycle_req, .exposure_req, .pixels_wanted, .pix_data, .pix_valid, .pix_ready,
		.frame_done, .overrun, .scan_busy);
	scan_link_monitor u_scan_link_monitor(.sys_clk, .rstn,
		.scan_start(u_scan_link_if.scan_start), .trig(u_scan_link_if.trig),
		.video(u_scan_link_if.video), .scan_done(u_scan_link_if.scan_done));
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	function automatic logic [7:0] pat(input int i);
		return i[7:0] ^ 8'h3c;
	endfunction : pat
	task check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("Error t=%0t seen=%h expected=%h", $time, seen, want);
		end
	endtask : check
	task complete_run;
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	// wait for the end of a scan, then let the fifo drain
	task wait_done;
		int k;
		k = 0;
		while (frame_done !== 1'b1 && k < 2000) begin
			tick(1);
			k++;
		end
		if (k == 2000) n_fail++;
		tick(40);
	endtask : wait_done
	// one scan from a table row, then wait for its end and the drain
	task run_scan(input row_t r);
		exposure_req = r.expo;
		cycle_req = r.cyc;
		pixels_wanted = r.want;
		modn = (r.want == 0) ? 1 : (r.want > 512) ? 512 : int'(r.want);
		got = 0;
		run = 1'b1;
		tick(1);
		run = 1'b0;
		wait_done();
	endtask : run_scan
	// cycle count and run ceiling
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	// samples leaving the fifo, in pixel order, read away from the launching edge
	always @(negedge sys_clk) begin
		if (rstn === 1'b1 && pix_valid === 1'b1 && pix_ready === 1'b1) begin
			check({24'h0, pix_data}, {24'h0, pat(got % modn)});
			got++;
		end
	end
	// scan-start rises, sampled away from the launching edge
	always @(negedge sys_clk) begin
		if (u_scan_link_if.scan_start === 1'b1 && ss_q === 1'b0) rise_q.push_back(cycles);
		ss_q = u_scan_link_if.scan_start;
	end
	initial begin
		rstn = 1'b0; run = 1'b0; pix_ready = 1'b1; pix_wr_en = 1'b0; pix_wr_addr = 9'h000;
		pix_wr_data = 8'h00; cycle_req = '0; exposure_req = '0; pixels_wanted = '0; modn = 1;
		tick(16);
		check({u_scan_link_if.scan_start, u_scan_link_if.trig, pix_valid, overrun}, 0);
		rstn = 1'b1;
		for (int i = 0; i < 512; i++) begin
			pix_wr_en = 1'b1;
			pix_wr_addr = i[8:0];
			pix_wr_data = pat(i);
			tick(1);
		end
		pix_wr_en = 1'b0;
		foreach (rows[i]) begin
			run_scan(rows[i]);
			check(exposure_cycles, rows[i].h_exp);
			check(got, rows[i].n_exp);
		end
		// back-to-back short scans at the shortest period
		exposure_req = 23'h000006; cycle_req = '0; pixels_wanted = 10'h020; modn = 32; got = 0;
		rise_q.delete();
		run = 1'b1;
		while (rise_q.size() < 3) tick(1);
		check(scan_busy, 1);
		run = 1'b0;
		wait_done();
		check(rise_q[1] - rise_q[0], 84);
		check(rise_q[2] - rise_q[1], 84);
		check(rise_q.size(), 3);
		check(got, 96);
		// full scan into a stalled fifo
		pix_ready = 1'b0;
		run_scan(rows[2]);
		check({overrun, readout_busy}, 2);
		pix_ready = 1'b1;
		tick(40);
		check(got, 16);
		// reset in mid-scan, then recovery
		run = 1'b1;
		tick(100);
		rstn = 1'b0;
		tick(2);
		check({u_scan_link_if.scan_start, u_scan_link_if.trig, overrun, scan_busy}, 0);
		run = 1'b0;
		rstn = 1'b1;
		run_scan(rows[0]);
		check(got, 4);
		complete_run();
	end
endmodule : linear_sensor_scan_timing_tb
`default_nettype wire

//--- bench/scan_link_monitor.sv
// checker on the wires between sensor and controller
`timescale 1ns/1ps
`default_nettype none
module scan_link_monitor
	import scan_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic scan_start,
	input wire logic trig,
	input wire logic [VIDEO_W-1:0] video,
	input wire logic scan_done
);
	// ------------------------------------------------------------
	// cycle counters behind the assertions
	// ------------------------------------------------------------
	logic [11:0] lo_cnt;
	logic [11:0] per_cnt;
	logic [11:0] pls;
	logic armed;
	logic prev;
	// low run, rise-to-rise span and strobe count since the fall
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lo_cnt <= 12'h000;
			per_cnt <= 12'h000;
			pls <= 12'h000;
			armed <= 1'b0;
			prev <= 1'b0;
		end else begin
			prev <= scan_start;
			lo_cnt <= scan_start ? 12'h000 : lo_cnt + {11'h000, lo_cnt != 12'hfff};
			per_cnt <= (scan_start && !prev) ? 12'h001 : per_cnt + {11'h000, per_cnt != 12'hfff};
			armed <= armed | (scan_start & ~prev);
			pls <= (prev && !scan_start) ? 12'h000 : pls + {11'h000, trig};
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_held_high; scan_start [*6]; endsequence
	sequence s_done_pulse; scan_done ##1 !scan_done; endsequence
	property p_high_min; $rose(scan_start) |-> s_held_high; endproperty
	property p_low_min; $rose(scan_start) && armed |-> lo_cnt >= 12'd52; endproperty
	property p_interval; $rose(scan_start) && armed |-> per_cnt >= 12'd58; endproperty
	property p_shift_start; $fell(scan_start) |=> trig; endproperty
	property p_trig_cause; $rose(trig) |-> $past(scan_start, 2) && !$past(scan_start); endproperty
	property p_one_per_clock; trig && pls < 12'd559 |=> trig; endproperty
	property p_done_at_end; trig && pls == 12'd559 |=> s_done_pulse; endproperty
	property p_done_cause; scan_done |-> pls == 12'd560 && !trig; endproperty
	property p_video_step; $changed(video) |-> trig; endproperty
	a_high_min: assert property (p_high_min)
		else $error("start high period too short");
	a_low_min: assert property (p_low_min)
		else $error("start low period too short");
	a_interval: assert property (p_interval)
		else $error("start rises too close");
	a_shift_start: assert property (p_shift_start)
		else $error("no strobe after start fall");
	a_trig_cause: assert property (p_trig_cause)
		else $error("strobe began without start fall");
	a_one_per_clock: assert property (p_one_per_clock)
		else $error("strobe gap inside readout");
	a_done_at_end: assert property (p_done_at_end)
		else $error("no single done pulse after last strobe");
	a_done_cause: assert property (p_done_cause)
		else $error("done pulse at wrong strobe count");
	a_video_step: assert property (p_video_step)
		else $error("video moved outside a strobe");
endmodule : scan_link_monitor
`default_nettype wire

//--- design/scan_ctrl.sv
// controller end: scan-start timing, pixel capture and the sample fifo
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// synchronous fifo with valid and ready on both sides
// ------------------------------------------------------------
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0] level, next_level;
	logic push, pop;
	logic next_out_valid;
	logic [WIDTH-1:0] next_out_data;

	assign in_ready = (level != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and level update
	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_level = level;
		if (push && !pop) begin
			next_level = level + 1'b1;
		end else if (pop && !push) begin
			next_level = level - 1'b1;
		end
		// head word and valid are registered so the read side sees flops
		next_out_valid = (next_level != '0);
		// a word landing in the slot that becomes the head goes straight through
		next_out_data = (push && wr_ptr == next_rd_ptr) ? in_data : mem[next_rd_ptr];
	end

	// storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointer registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			level <= next_level;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
		end
	end
endmodule : sample_fifo

module scan_ctrl
	import scan_pkg::*;
#(
	parameter int MAX_CYCLES = MAX_INTERVAL_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	scan_link_if.ctrl lnk,
	input wire logic run,
	input wire logic [TIME_W-1:0] cycle_req,
	input wire logic [TIME_W-1:0] exposure_req,
	input wire logic [CNT_W-1:0] pixels_wanted,
	output logic [VIDEO_W-1:0] pix_data,
	output logic pix_valid,
	input wire logic pix_ready,
	output logic frame_done,
	output logic overrun,
	output logic scan_busy
);
	// ------------------------------------------------------------
	// settings clamped to the sensor limits
	// ------------------------------------------------------------
	localparam logic [TIME_W-1:0] MAX_CYC = TIME_W'(MAX_CYCLES);
	logic [TIME_W-1:0] want_high, want_cycle;
	logic [CNT_W-1:0] want_pix;

	// derive legal high time and cycle from the request
	always_comb begin
		want_pix = (pixels_wanted > PIXEL_COUNT) ? PIXEL_COUNT : pixels_wanted;
		want_high = (exposure_req < MIN_HIGH) ? MIN_HIGH : exposure_req;
		if (want_high > MAX_CYC - MIN_LOW) begin
			want_high = MAX_CYC - MIN_LOW;
		end
		want_cycle = cycle_req;
		if (want_cycle < want_high + MIN_LOW) begin
			want_cycle = want_high + MIN_LOW;
		end
		if (want_pix <= PARTIAL_PIXELS) begin
			if (want_cycle < PARTIAL_CYCLE) begin
				want_cycle = PARTIAL_CYCLE;
			end
		end else if (want_cycle < FULL_CYCLE) begin
			want_cycle = FULL_CYCLE;
		end
		if (want_cycle < MIN_INTERVAL) begin
			want_cycle = MIN_INTERVAL;
		end
		if (want_cycle > MAX_CYC) begin
			want_cycle = MAX_CYC;
		end
	end

	// ------------------------------------------------------------
	// scan-start generator
	// ------------------------------------------------------------
	ctl_state_t state, next_state;
	logic [TIME_W-1:0] timer, next_timer;
	logic [TIME_W-1:0] cur_high, next_cur_high, cur_cycle, next_cur_cycle;
	logic [CNT_W-1:0] cur_pix, next_cur_pix;
	logic start, next_start;
	logic fifo_in_ready;

	// start pulse sequencing, held at cycle end while the fifo is full
	always_comb begin
		next_state = state;
		next_timer = timer + 1'b1;
		next_cur_high = cur_high;
		next_cur_cycle = cur_cycle;
		next_cur_pix = cur_pix;
		next_start = start;
		unique case (state)
			CTL_IDLE: begin
				next_timer = '0;
				if (run) begin
					next_state = CTL_HIGH;
					next_start = 1'b1;
					next_cur_high = want_high;
					next_cur_cycle = want_cycle;
					next_cur_pix = want_pix;
				end
			end
			CTL_HIGH: begin
				if (next_timer == cur_high) begin
					next_state = CTL_LOW;
					next_start = 1'b0;
				end
			end
			CTL_LOW: begin
				if (next_timer >= cur_cycle) begin
					next_timer = timer;
					if (fifo_in_ready) begin
						next_timer = '0;
						next_state = run ? CTL_HIGH : CTL_IDLE;
						next_start = run;
						next_cur_high = want_high;
						next_cur_cycle = want_cycle;
						next_cur_pix = want_pix;
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// pixel capture
	// ------------------------------------------------------------
	logic [CNT_W-1:0] pulse_cnt, next_pulse_cnt;
	logic [CNT_W-1:0] pix_num;
	logic take, overrun_set, next_overrun;
	logic fall_seen, next_fall_seen;

	assign pix_num = pulse_cnt - LEAD_PULSES;

	// strobe cycle is the sample point
	always_comb begin
		next_pulse_cnt = pulse_cnt;
		take = 1'b0;
		// the sensor sees the fall one edge after start drops, so restart then
		next_fall_seen = start && !next_start;
		if (fall_seen) begin
			next_pulse_cnt = '0;
		end else if (lnk.trig) begin
			next_pulse_cnt = pulse_cnt + 1'b1;
			take = (pulse_cnt >= LEAD_PULSES) && (pix_num < cur_pix);
		end
		overrun_set = take && !fifo_in_ready;
		next_overrun = overrun || overrun_set;
	end

	sample_fifo #(
		.WIDTH(VIDEO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(take),
		.in_ready(fifo_in_ready),
		.in_data(lnk.video),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data(pix_data)
	);

	// registers of the generator and capture
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= CTL_IDLE;
			timer <= '0;
			cur_high <= MIN_HIGH;
			cur_cycle <= FULL_CYCLE;
			cur_pix <= PIXEL_COUNT;
			start <= 1'b0;
			pulse_cnt <= '0;
			fall_seen <= 1'b0;
			overrun <= 1'b0;
			frame_done <= 1'b0;
			scan_busy <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			cur_high <= next_cur_high;
			cur_cycle <= next_cur_cycle;
			cur_pix <= next_cur_pix;
			start <= next_start;
			pulse_cnt <= next_pulse_cnt;
			fall_seen <= next_fall_seen;
			overrun <= next_overrun;
			frame_done <= lnk.scan_done;
			scan_busy <= (next_state != CTL_IDLE);
		end
	end

	// link runs on sys_clk at 50 MHz
	assign lnk.scan_start = start;
endmodule : scan_ctrl
`default_nettype wire

//--- design/scan_link_if.sv
// wires between the sensor and its controller
`timescale 1ns/1ps
`default_nettype none
interface scan_link_if;
	import scan_pkg::*;
	logic scan_start;
	logic trig;
	logic [VIDEO_W-1:0] video;
	logic scan_done;
	modport sensor (input scan_start, output trig, output video, output scan_done);
	modport ctrl (output scan_start, input trig, input video, input scan_done);
endinterface : scan_link_if
`default_nettype wire

//--- design/scan_pkg.sv
// constants and types shared by the sensor end and the controller end
package scan_pkg;
	// ------------------------------------------------------------
	// clock and widths
	// ------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 50;
	localparam int VIDEO_W = 8;
	localparam int CNT_W = 10;
	localparam int TIME_W = 23;
	localparam int FIFO_DEPTH = 16;
	// ------------------------------------------------------------
	// readout geometry
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] PIXEL_COUNT = 10'h200;
	localparam logic [CNT_W-1:0] LEAD_PULSES = 10'h030;
	localparam logic [CNT_W-1:0] TRIG_TOTAL = 10'h230;
	localparam logic [CNT_W-1:0] PARTIAL_PIXELS = 10'h020;
	// ------------------------------------------------------------
	// scan-start timing in clock periods
	// ------------------------------------------------------------
	localparam logic [TIME_W-1:0] MIN_HIGH = 23'h000006;
	localparam logic [TIME_W-1:0] MIN_LOW = 23'h000034;
	localparam logic [TIME_W-1:0] MIN_INTERVAL = 23'h00003a;
	localparam logic [TIME_W-1:0] FULL_CYCLE = 23'h000234;
	localparam logic [TIME_W-1:0] PARTIAL_CYCLE = 23'h000054;
	localparam int MAX_INTERVAL_MS = 100;
	// milliseconds to microseconds, then clock periods per microsecond
	localparam int MAX_INTERVAL_CYCLES = MAX_INTERVAL_MS * 1000 * CLK_FREQ_MHZ;
	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {CTL_IDLE, CTL_HIGH, CTL_LOW} ctl_state_t;
	typedef enum logic {RD_IDLE, RD_SHIFT} rd_state_t;
endpackage : scan_pkg

//--- design/scan_sensor.sv
// sensor end: timing generator, pixel shift-out, exposure measure
`timescale 1ns/1ps
`default_nettype none
module scan_sensor
	import scan_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	scan_link_if.sensor lnk,
	input wire logic pix_wr_en,
	input wire logic [8:0] pix_wr_addr,
	input wire logic [VIDEO_W-1:0] pix_wr_data,
	output logic [TIME_W-1:0] exposure_cycles,
	output logic readout_busy
);
	// ------------------------------------------------------------
	// scene memory, one word per pixel
	// ------------------------------------------------------------
	logic [VIDEO_W-1:0] scene [0:PIXEL_COUNT-1];

	// write port for the image the user wants to see
	always_ff @(posedge sys_clk) begin
		if (pix_wr_en) begin
			scene[pix_wr_addr] <= pix_wr_data;
		end
	end

	// ------------------------------------------------------------
	// readout sequencer
	// ------------------------------------------------------------
	rd_state_t state, next_state;
	logic start_q, next_start_q;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [TIME_W-1:0] high_cnt, next_high_cnt;
	logic [TIME_W-1:0] next_exposure;
	logic trig, next_trig;
	logic [VIDEO_W-1:0] video, next_video;
	logic done, next_done;

	// next-state logic for the shift sequence
	always_comb begin
		next_state = state;
		next_start_q = lnk.scan_start;
		next_cnt = cnt;
		next_high_cnt = high_cnt;
		next_exposure = exposure_cycles;
		next_trig = 1'b0;
		next_video = video;
		next_done = 1'b0;
		if (lnk.scan_start && high_cnt != '1) begin
			next_high_cnt = high_cnt + 1'b1;
		end
		if (!lnk.scan_start) begin
			next_high_cnt = '0;
		end
		if (start_q && !lnk.scan_start) begin
			next_exposure = high_cnt;
			next_state = RD_SHIFT;
			next_cnt = '0;
			next_trig = 1'b1;
		end else begin
			unique case (state)
				RD_IDLE: begin
					next_cnt = '0;
				end
				RD_SHIFT: begin
					next_cnt = cnt + 1'b1;
					if (next_cnt < TRIG_TOTAL) begin
						next_trig = 1'b1;
					end else begin
						next_done = 1'b1;
						next_state = RD_IDLE;
					end
				end
			endcase
		end
		if (next_trig && next_cnt >= LEAD_PULSES) begin
			next_video = scene[9'(next_cnt - LEAD_PULSES)];
		end
	end

	// state registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= RD_IDLE;
			start_q <= 1'b0;
			cnt <= '0;
			high_cnt <= '0;
			exposure_cycles <= '0;
			trig <= 1'b0;
			video <= '0;
			done <= 1'b0;
			readout_busy <= 1'b0;
		end else begin
			state <= next_state;
			start_q <= next_start_q;
			cnt <= next_cnt;
			high_cnt <= next_high_cnt;
			exposure_cycles <= next_exposure;
			trig <= next_trig;
			video <= next_video;
			done <= next_done;
			readout_busy <= (next_state == RD_SHIFT);
		end
	end

	// link outputs straight from flops
	assign lnk.trig = trig;
	assign lnk.video = video;
	assign lnk.scan_done = done;
endmodule : scan_sensor
`default_nettype wire
